// >>> rtl/spisr_defs.svh
`ifndef SPISR_DEFS_SVH
`define SPISR_DEFS_SVH

// Register indices; byte address is four times the index
`define SPISR_IDX_DATA      6'h11
`define SPISR_IDX_CTRL      6'h12
`define SPISR_IDX_CSR       6'h13

// serial_control field positions
`define SPISR_CTL_IE        7
`define SPISR_CTL_PE        6
`define SPISR_CTL_RDE       5
`define SPISR_CTL_MS        4
`define SPISR_CTL_CLOCK_POLARITY      3
`define SPISR_CTL_CLOCK_PHASE      2
`define SPISR_CTL_RSH       1
`define SPISR_CTL_RSL       0

// serial_control_status field positions
`define SPISR_CSR_TC        7
`define SPISR_CSR_WRITE_COLLISION_FLAG      6
`define SPISR_CSR_OVR       5
`define SPISR_CSR_MASTER_FAULT_FLAG      4
`define SPISR_CSR_RSVD      3
`define SPISR_CSR_ORL       2
`define SPISR_CSR_SSM       1
`define SPISR_CSR_SSI       0

// Reset values
`define SPISR_CTRL_RST      8'h00
`define SPISR_CSR_RST       8'h00
`define SPISR_DATA_RST      8'h00
`define SPISR_PIN_RST       4'hf

// Rate codes {divider_enable, select_hi, select_lo}
`define SPISR_RATE_DIV4     3'h4
`define SPISR_RATE_DIV8     3'h0
`define SPISR_RATE_DIV16    3'h1
`define SPISR_RATE_DIV32    3'h6
`define SPISR_RATE_DIV64    3'h2
`define SPISR_RATE_DIV128   3'h3

// Half serial clock periods in system clocks
`define SPISR_HALF_DIV4     7'h02
`define SPISR_HALF_DIV8     7'h04
`define SPISR_HALF_DIV16    7'h08
`define SPISR_HALF_DIV32    7'h10
`define SPISR_HALF_DIV64    7'h20
`define SPISR_HALF_DIV128   7'h40

// Sixteen serial clock edges make one byte
`define SPISR_LAST_EDGE     5'h0f

// Pin vector positions after synchronisation
`define SPISR_PIN_SCK       0
`define SPISR_PIN_MOSI      1
`define SPISR_PIN_MISO      2
`define SPISR_PIN_SS        3

`endif

// >>> rtl/spisr_pkg.sv
package spisr_pkg;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] lvl;
	} spisr_sync_s;

	typedef struct packed {
		logic       ack;
		logic [7:0] dat;
		logic [7:0] ctrl;
		logic       orl;
		logic       soft_select_manage;
		logic       soft_select_level;
		logic       tc;
		logic       write_collision_flag;
		logic       overrun_flag;
		logic       master_fault_flag;
		logic       arm_tc;
		logic       arm_write_collision_flag;
		logic       arm_master_fault_flag;
		logic [7:0] rxbuf;
		logic [7:0] sr;
		logic       out_bit;
		logic [4:0] edge_cnt;
		logic       busy;
		logic [6:0] div_cnt;
		logic       sck_int;
		logic       sck_prev;
		logic       irq;
		logic       sck_o;
		logic       sck_oe_n;
		logic       mosi_o;
		logic       mosi_oe_n;
		logic       miso_o;
		logic       miso_oe_n;
	} spisr_state_s;

endpackage : spisr_pkg

// >>> rtl/spisr_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "spisr_defs.svh"

module spisr_sync
	import spisr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] pin_i,
	output logic      [3:0] level_o
);

	spisr_sync_s s;
	spisr_sync_s n;

	// Level follows once stages two and three agree
	always_comb begin
		n     = s;
		n.s1  = pin_i;
		n.s2  = s.s1;
		n.s3  = s.s2;
		n.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 ^ s.s3));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '{s1: `SPISR_PIN_RST, s2: `SPISR_PIN_RST, s3: `SPISR_PIN_RST, lvl: `SPISR_PIN_RST};
		end else begin
			s <= n;
		end
	end

	assign level_o = s.lvl;

endmodule : spisr_sync
`default_nettype wire

// >>> rtl/spisr_top.sv
// Contract
// - Byte done sets transfer_done_flag bit 7; interrupt when enabled.
// - transfer_done_flag clears after status read then data read or write.
// - Data writes ignored while transfer_done_flag set until status read.
// - Data write during a transfer sets read-only write_collision_flag bit 6.
// - Byte arriving while transfer_done_flag set sets overrun_flag bit 5.
// - Status register read clears overrun_flag.
// - Select low in master mode sets master_fault_flag bit 4.
// - master_fault_flag clears on status read while set, then control write.
// - Status bit 3 reserved: reads zero, write as zero.
// - output_release bit 2 releases data output pin; else driven when enabled, as slave only while selected.
// - soft_select_manage bit 1 ignores select pin, uses soft_select_level.
// - soft_select_level bit 0: zero selects, one deselects.
// - Master: data write starts shifting one byte out and in.
// - Received byte copied to buffer at end unless transfer_done_flag set; data reads return buffer.
// - Data write loads shift register directly, no transmit buffer.
// - Reset clears status and upper control bits.
// - Data, control, status at indices 11h, 12h, 13h.
// - Interrupt when enabled and any done, fault or overrun flag set.
// - Master fault clears peripheral_enable and master_select in hardware.
// - Serial pins belong to the block only while peripheral_enable set.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "spisr_defs.svh"

module spisr_top
	import spisr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:2]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_n_o,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_n_o,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_n_o,
	input  wire logic        ss_n_i,
	output logic             irq_o
);

	spisr_state_s s;
	spisr_state_s n;
	logic [3:0]   pins;

	logic         req;
	logic         rd;
	logic         wr;
	logic         hit_data;
	logic         hit_ctrl;
	logic         hit_csr;
	logic         sel_n;
	logic         mst_on;
	logic         slv_on;
	logic         slv_sel;
	logic         edge_ev;
	logic         lead;
	logic         sample;
	logic         shift;
	logic         in_bit;
	logic         blocked;

	// Pin inputs cross into the clock domain here
	spisr_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   ({ss_n_i, miso_i, mosi_i, sck_i}),
		.level_o (pins)
	);

	// Half serial clock period for the master rate code
	function automatic logic [6:0] half_period(input logic [2:0] code);
		case (code)
			`SPISR_RATE_DIV4:   half_period = `SPISR_HALF_DIV4;
			`SPISR_RATE_DIV8:   half_period = `SPISR_HALF_DIV8;
			`SPISR_RATE_DIV16:  half_period = `SPISR_HALF_DIV16;
			`SPISR_RATE_DIV32:  half_period = `SPISR_HALF_DIV32;
			`SPISR_RATE_DIV64:  half_period = `SPISR_HALF_DIV64;
			`SPISR_RATE_DIV128: half_period = `SPISR_HALF_DIV128;
			default:            half_period = `SPISR_HALF_DIV128;
		endcase
	endfunction : half_period

	// Status register as seen by software
	function automatic logic [7:0] csr_view(input spisr_state_s st);
		logic [7:0] v;
		v                  = 8'h00;
		v[`SPISR_CSR_TC]   = st.tc;
		v[`SPISR_CSR_WRITE_COLLISION_FLAG] = st.write_collision_flag;
		v[`SPISR_CSR_OVR]  = st.overrun_flag;
		v[`SPISR_CSR_MASTER_FAULT_FLAG] = st.master_fault_flag;
		v[`SPISR_CSR_RSVD] = 1'b0;
		v[`SPISR_CSR_ORL]  = st.orl;
		v[`SPISR_CSR_SSM]  = st.soft_select_manage;
		v[`SPISR_CSR_SSI]  = st.soft_select_level;
		csr_view           = v;
	endfunction : csr_view

	// Register index decode
	function automatic logic idx_hit(input logic [7:2] adr, input logic [5:0] idx);
		idx_hit = (adr == idx);
	endfunction : idx_hit

	always_comb begin
		n        = s;
		req      = cyc_i & stb_i & ~s.ack;
		rd       = req & ~we_i;
		wr       = req & we_i & sel_i[0];
		hit_data = idx_hit(adr_i, `SPISR_IDX_DATA);
		hit_ctrl = idx_hit(adr_i, `SPISR_IDX_CTRL);
		hit_csr  = idx_hit(adr_i, `SPISR_IDX_CSR);
		sel_n    = s.soft_select_manage ? s.soft_select_level : pins[`SPISR_PIN_SS];
		blocked  = s.tc & ~s.arm_tc;
		edge_ev  = 1'b0;
		lead     = 1'b0;
		sample   = 1'b0;
		shift    = 1'b0;
		in_bit   = 1'b0;

		// Bus slave: one ack per request, unmapped reads return zero
		n.ack = req;
		n.dat = 8'h00;

		if (rd && hit_csr) begin
			n.dat      = csr_view(s);
			n.overrun_flag      = 1'b0;
			n.arm_tc   = s.tc;
			n.arm_write_collision_flag = s.write_collision_flag;
			n.arm_master_fault_flag = s.master_fault_flag;
		end
		if (rd && hit_ctrl) begin
			n.dat = s.ctrl;
		end
		if (rd && hit_data) begin
			n.dat = s.rxbuf;
			if (s.arm_tc) begin
				n.tc     = 1'b0;
				n.arm_tc = 1'b0;
			end
			if (s.arm_write_collision_flag) begin
				n.write_collision_flag     = 1'b0;
				n.arm_write_collision_flag = 1'b0;
			end
		end
		if (wr && hit_ctrl) begin
			n.ctrl = dat_i[7:0];
			if (s.arm_master_fault_flag) begin
				n.master_fault_flag     = 1'b0;
				n.arm_master_fault_flag = 1'b0;
			end
		end
		if (wr && hit_csr) begin
			n.orl = dat_i[`SPISR_CSR_ORL];
			n.soft_select_manage = dat_i[`SPISR_CSR_SSM];
			n.soft_select_level = dat_i[`SPISR_CSR_SSI];
		end
		if (wr && hit_data && !blocked) begin
			if (s.arm_tc) begin
				n.tc     = 1'b0;
				n.arm_tc = 1'b0;
			end
			if (s.busy) begin
				n.write_collision_flag = 1'b1;
			end else begin
				n.sr      = dat_i[7:0];
				n.out_bit = dat_i[7];
				if (s.ctrl[`SPISR_CTL_PE] && s.ctrl[`SPISR_CTL_MS]) begin
					n.busy     = 1'b1;
					n.edge_cnt = 5'h00;
					n.div_cnt  = 7'h00;
					n.sck_int  = s.ctrl[`SPISR_CTL_CLOCK_POLARITY];
				end
			end
		end

		mst_on     = s.ctrl[`SPISR_CTL_PE] & s.ctrl[`SPISR_CTL_MS];
		slv_on     = s.ctrl[`SPISR_CTL_PE] & ~s.ctrl[`SPISR_CTL_MS];
		slv_sel    = slv_on & ~sel_n;
		n.sck_prev = pins[`SPISR_PIN_SCK];

		// Edge source: own divider as master, sampled clock as slave
		if (mst_on && s.busy) begin
			if (s.div_cnt == half_period({s.ctrl[`SPISR_CTL_RDE], s.ctrl[`SPISR_CTL_RSH],
				s.ctrl[`SPISR_CTL_RSL]}) - 7'h01) begin
				n.div_cnt = 7'h00;
				n.sck_int = ~s.sck_int;
				edge_ev   = 1'b1;
			end else begin
				n.div_cnt = s.div_cnt + 7'h01;
			end
			in_bit = pins[`SPISR_PIN_MISO];
		end else if (slv_sel) begin
			edge_ev = (pins[`SPISR_PIN_SCK] != s.sck_prev);
			in_bit  = pins[`SPISR_PIN_MOSI];
		end else if (slv_on) begin
			// Deselected slave restarts its byte and presents the MSB again
			n.busy     = 1'b0;
			n.edge_cnt = 5'h00;
			n.out_bit  = n.sr[7];
		end

		// Even edge counts are leading edges, odd ones trailing
		lead   = edge_ev & ~s.edge_cnt[0];
		sample = s.ctrl[`SPISR_CTL_CLOCK_PHASE] ? (edge_ev & ~lead) : lead;
		shift  = s.ctrl[`SPISR_CTL_CLOCK_PHASE] ? lead : (edge_ev & ~lead & (s.edge_cnt != `SPISR_LAST_EDGE));

		if (sample) begin
			n.sr = {s.sr[6:0], in_bit};
		end
		if (shift) begin
			n.out_bit = s.sr[7];
		end
		if (edge_ev) begin
			n.busy = 1'b1;
			if (s.edge_cnt == `SPISR_LAST_EDGE) begin
				n.busy     = 1'b0;
				n.edge_cnt = 5'h00;
				if (n.tc) begin
					n.overrun_flag = 1'b1;
				end else begin
					n.rxbuf = n.sr;
					n.tc    = 1'b1;
				end
			end else begin
				n.edge_cnt = s.edge_cnt + 5'h01;
			end
		end

		// Fault wins over a control write in the same cycle
		if (s.ctrl[`SPISR_CTL_MS] && !sel_n) begin
			n.master_fault_flag                  = 1'b1;
			n.ctrl[`SPISR_CTL_PE]   = 1'b0;
			n.ctrl[`SPISR_CTL_MS]   = 1'b0;
			n.busy                  = 1'b0;
			n.edge_cnt              = 5'h00;
		end
		if (!n.ctrl[`SPISR_CTL_PE]) begin
			n.busy     = 1'b0;
			n.edge_cnt = 5'h00;
		end
		if (!n.busy) begin
			n.div_cnt = 7'h00;
			n.sck_int = n.ctrl[`SPISR_CTL_CLOCK_POLARITY];
		end

		// Pin drivers; enables are active low
		n.sck_o     = n.sck_int;
		n.sck_oe_n  = ~(n.ctrl[`SPISR_CTL_PE] & n.ctrl[`SPISR_CTL_MS]);
		n.mosi_o    = n.out_bit;
		n.mosi_oe_n = ~(n.ctrl[`SPISR_CTL_PE] & n.ctrl[`SPISR_CTL_MS] & ~n.orl);
		n.miso_o    = n.out_bit;
		n.miso_oe_n = ~(n.ctrl[`SPISR_CTL_PE] & ~n.ctrl[`SPISR_CTL_MS] & ~n.orl & ~sel_n);

		n.irq = n.ctrl[`SPISR_CTL_IE] & (n.tc | n.master_fault_flag | n.overrun_flag);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s           <= '0;
			s.ctrl      <= `SPISR_CTRL_RST;
			s.rxbuf     <= `SPISR_DATA_RST;
			s.sck_prev  <= 1'b1;
			s.sck_oe_n  <= 1'b1;
			s.mosi_oe_n <= 1'b1;
			s.miso_oe_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign dat_o       = {24'h000000, s.dat};
	assign ack_o       = s.ack;
	assign sck_o       = s.sck_o;
	assign sck_oe_n_o  = s.sck_oe_n;
	assign mosi_o      = s.mosi_o;
	assign mosi_oe_n_o = s.mosi_oe_n;
	assign miso_o      = s.miso_o;
	assign miso_oe_n_o = s.miso_oe_n;
	assign irq_o       = s.irq;

endmodule : spisr_top
`default_nettype wire

// >>> verif/spisr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spisr_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:2]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        sck_oe_n_o,
	input wire logic        mosi_oe_n_o,
	input wire logic        miso_oe_n_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence bus_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence bus_read;
		bus_req ##0 !we_i;
	endsequence
	sequence ctrl_off;
		bus_req ##0 (we_i && sel_i[0] && adr_i == 6'h12 && !dat_i[6]);
	endsequence
	chk_ack_next: assert property (bus_req |=> ack_o)
		else $error("bus request not acknowledged");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_unmapped_zero: assert property (bus_read ##0 (adr_i < 6'h11 || adr_i > 6'h13) |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_rsvd_zero: assert property (bus_read ##0 adr_i == 6'h13 |=> dat_o[31:8] == 24'h0 && !dat_o[3])
		else $error("reserved status bit not zero");
	chk_reset_idle: assert property ($past(rst_i) |-> !irq_o && !ack_o && sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o)
		else $error("outputs active after reset");
	chk_out_exclusive: assert property (!(mosi_oe_n_o == 1'b0 && miso_oe_n_o == 1'b0))
		else $error("both data outputs driven");
	chk_mosi_with_sck: assert property (!mosi_oe_n_o |-> !sck_oe_n_o)
		else $error("data out driven without clock out");
	chk_pins_freed: assert property (ctrl_off |-> ##[1:2] (sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o))
		else $error("pins kept after disable");
endmodule : spisr_checker
bind spisr_top spisr_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sck_oe_n_o(sck_oe_n_o),
	.mosi_oe_n_o(mosi_oe_n_o), .miso_oe_n_o(miso_oe_n_o), .irq_o(irq_o));
`default_nettype wire

// >>> verif/spisr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spisr_slave_model (
	input wire logic       sck_i,
	input wire logic       mosi_i,
	input wire logic       ss_n_i,
	input wire logic [7:0] tx_i,
	output logic           miso_o,
	output logic     [7:0] rx_o
);
	logic [7:0] sh;
	initial rx_o = 8'h00;
	always @(negedge ss_n_i) sh = tx_i;
	always @(posedge sck_i) if (!ss_n_i) rx_o <= {rx_o[6:0], mosi_i};
	always @(negedge sck_i) if (!ss_n_i) sh <= {sh[6:0], 1'b0};
	// Released line shows inverted data
	assign miso_o = ss_n_i ? ~sh[7] : sh[7];
endmodule : spisr_slave_model
`default_nettype wire

// >>> verif/spisr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spisr_top_tb;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, sck_b, mosi_b, ss_n_i, p_ss_n, p_miso;
	logic        ack_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, irq_o;
	logic [7:2]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o;
	logic [7:0]  rq, x, t, g, p_rx, p_tx;
	int          failures, tests_run, seed, cyc_cnt, n;
	wire sck_w = sck_oe_n_o ? sck_b : sck_o;
	wire mosi_w = mosi_oe_n_o ? mosi_b : mosi_o;
	wire miso_w = miso_oe_n_o ? p_miso : miso_o;
	spisr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w),
		.miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n_i), .irq_o(irq_o));
	spisr_slave_model u_peer (.sck_i(sck_w), .mosi_i(mosi_w), .ss_n_i(p_ss_n), .tx_i(p_tx), .miso_o(p_miso),
		.rx_o(p_rx));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	function automatic logic [7:0] ecsr(input logic tc, wc, ov, mf, input logic [2:0] lo);
		return {tc, wc, ov, mf, 1'b0, lo};
	endfunction : ecsr
	task end_of_test;
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task chk(input logic [7:0] e, input logic [7:0] s, input string nm);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rq = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	// Bench as link master, 320 ns serial clock
	task sx(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			mosi_b <= d[i];
			repeat (4) @(posedge clk_i);
			sck_b <= 1'b1;
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			g[i] = miso_w;
			@(posedge clk_i);
			sck_b <= 1'b0;
		end
	endtask : sx
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			failures++;
			end_of_test;
		end
	end
	initial begin
		seed = 42980;
		{failures, tests_run, cyc_cnt} = '0;
		{rst_i, cyc_i, stb_i, we_i, sck_b, mosi_b, ss_n_i, p_ss_n} = 8'h83;
		{adr_i, dat_i, p_tx} = '0;
		sel_i = 4'h1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 6'h12, 0);
		chk(8'h00, rq, "ctrl reset");
		wb(0, 6'h13, 0);
		chk(ecsr(0, 0, 0, 0, 3'h0), rq, "csr reset");
		wb(0, 6'h10, 0);
		chk(8'h00, rq, "unmapped");
		wb(1, 6'h13, 8'h07);
		wb(0, 6'h13, 0);
		chk(ecsr(0, 0, 0, 0, 3'h7), rq, "csr rw");
		sel_i <= 4'he;
		wb(1, 6'h13, 8'h00);
		sel_i <= 4'h1;
		wb(0, 6'h13, 0);
		chk(ecsr(0, 0, 0, 0, 3'h7), rq, "csr lane gated");
		wb(1, 6'h13, 8'h03);
		wb(1, 6'h12, 8'hd1);
		repeat (3) begin
			x = $random(seed);
			p_tx = $random(seed);
			p_ss_n <= 1'b0;
			wb(1, 6'h11, x);
			wb(1, 6'h11, ~x);
			for (n = 0; n < 400 && irq_o !== 1'b1; n++) @(posedge clk_i);
			chk(8'h01, {7'h0, irq_o}, "irq done");
			wb(1, 6'h11, x ^ 8'h5a);
			wb(0, 6'h13, 0);
			chk(ecsr(1, 1, 0, 0, 3'h3), rq, "csr done");
			wb(0, 6'h11, 0);
			chk(p_tx, rq, "rx buffer");
			chk(x, p_rx, "mosi byte");
			wb(0, 6'h13, 0);
			chk(ecsr(0, 0, 0, 0, 3'h3), rq, "csr clear");
			p_ss_n <= 1'b1;
			repeat (300) @(posedge clk_i);
			chk(8'h00, {7'h0, irq_o}, "no restart");
		end
		wb(1, 6'h12, 8'h40);
		wb(1, 6'h13, 8'h00);
		ss_n_i <= 1'b0;
		x = $random(seed);
		t = $random(seed);
		wb(1, 6'h11, x);
		repeat (8) @(posedge clk_i);
		sx(t);
		chk(x, g, "miso byte");
		repeat (8) @(posedge clk_i);
		sx(~t);
		repeat (8) @(posedge clk_i);
		wb(0, 6'h13, 0);
		chk(ecsr(1, 0, 1, 0, 3'h0), rq, "csr overrun");
		chk(8'h00, {7'h0, irq_o}, "irq masked");
		wb(0, 6'h11, 0);
		chk(t, rq, "slave rx");
		wb(0, 6'h13, 0);
		chk(8'h00, rq, "csr after");
		wb(1, 6'h13, 8'h04);
		repeat (4) @(posedge clk_i);
		chk(8'h01, {7'h0, miso_oe_n_o}, "miso released");
		wb(1, 6'h13, 8'h00);
		repeat (4) @(posedge clk_i);
		chk(8'h00, {7'h0, miso_oe_n_o}, "miso driven");
		wb(1, 6'h12, 8'hd1);
		repeat (8) @(posedge clk_i);
		wb(0, 6'h13, 0);
		chk(ecsr(0, 0, 0, 1, 3'h0), rq, "csr fault");
		chk(8'h01, {7'h0, irq_o}, "irq fault");
		wb(0, 6'h12, 0);
		chk(8'h81, rq, "ctrl fault");
		ss_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		wb(1, 6'h12, 8'h00);
		wb(0, 6'h13, 0);
		chk(8'h00, rq, "fault clear");
		end_of_test;
	end
endmodule : spisr_top_tb
`default_nettype wire
